// [src/dtst_timer.sv]
// delay-to-start timer with an AXI4-Lite register slave
module dtst_timer #(
    parameter int unsigned MS_CYCLES = `DTST_MS_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // AXI4-Lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [`DTST_AW-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [`DTST_AW-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // block inputs
    input wire logic trigPin,
    input wire logic enablePin,
    input wire logic timerReset_n,
    input wire logic faultPin,
    input wire logic nestOut,
    // block output
    output logic timerOut
);
    import dtst_pkg::*;

    // ----------------------------------------------------------------
    // reset and pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] rstSh_q;
    logic rstSync_n;
    logic [3:0] pinMeta_q;
    logic [3:0] pinSync_q;
    logic trigSync, enaSync, runSync, faultSync;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstSh_q <= 2'h0;
        end else begin
            rstSh_q <= {rstSh_q[0], 1'b1};
        end
    end
    assign rstSync_n = rstSh_q[1];

    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            pinMeta_q <= 4'h4;
            pinSync_q <= 4'h4;
        end else begin
            pinMeta_q <= {faultPin, timerReset_n, enablePin, trigPin};
            pinSync_q <= pinMeta_q;
        end
    end
    assign {faultSync, runSync, enaSync, trigSync} = pinSync_q;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    dtst_ctrl_t ctrl_q;
    logic [14:0] tally_q;
    logic [2:0] soft_q;
    dtst_status_t status;
    dtst_state_t state_q;
    logic [14:0] acc_q;
    logic outQ;

    logic awHeld_q, wHeld_q, bvalid_q, rvalid_q;
    logic [`DTST_AW-1:0] awAddr_q;
    logic [31:0] wData_q, rdata_q;
    logic [3:0] wStrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic doWrite;
    logic [31:0] wrCtrl, wrTally, wrSoft;
    logic wrOk;

    assign awready = !awHeld_q;
    assign wready = !wHeld_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = !rvalid_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign doWrite = awHeld_q && wHeld_q && !bvalid_q;

    assign wrCtrl = dtst_merge({24'h000000, ctrl_q}, wData_q, wStrb_q);
    assign wrTally = dtst_merge({17'h00000, tally_q}, wData_q, wStrb_q);
    assign wrSoft = dtst_merge({29'h00000000, soft_q}, wData_q, wStrb_q);

    // bad unit codes and a zero tally are refused whole
    always_comb begin
        case (awAddr_q)
            `DTST_OFS_CTRL: wrOk = (wrCtrl[6:4] <= `DTST_UNIT_MAX);
            `DTST_OFS_TALLY: wrOk = (wrTally[14:0] >= `DTST_TALLY_MIN);
            `DTST_OFS_SOFT: wrOk = 1'b1;
            default: wrOk = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            awHeld_q <= 1'b0;
            awAddr_q <= '0;
        end else if (awvalid && !awHeld_q) begin
            awHeld_q <= 1'b1;
            awAddr_q <= awaddr;
        end else if (doWrite) begin
            awHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            wHeld_q <= 1'b0;
            wData_q <= '0;
            wStrb_q <= '0;
        end else if (wvalid && !wHeld_q) begin
            wHeld_q <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
        end else if (doWrite) begin
            wHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= `DTST_RESP_OKAY;
        end else if (doWrite) begin
            bvalid_q <= 1'b1;
            bresp_q <= wrOk ? `DTST_RESP_OKAY : `DTST_RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            ctrl_q <= `DTST_CTRL_RST;
            tally_q <= `DTST_TALLY_RST;
            soft_q <= `DTST_SOFT_RST;
        end else if (doWrite && wrOk) begin
            case (awAddr_q)
                `DTST_OFS_CTRL: ctrl_q <= wrCtrl[7:0];
                `DTST_OFS_TALLY: tally_q <= wrTally[14:0];
                `DTST_OFS_SOFT: soft_q <= wrSoft[2:0];
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `DTST_RESP_OKAY;
        end else if (arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= `DTST_RESP_OKAY;
            case (araddr)
                `DTST_OFS_CTRL: rdata_q <= {24'h000000, ctrl_q};
                `DTST_OFS_TALLY: rdata_q <= {17'h00000, tally_q};
                `DTST_OFS_STATUS: rdata_q <= {12'h000, status};
                `DTST_OFS_SOFT: rdata_q <= {29'h00000000, soft_q};
                default: begin
                    rdata_q <= '0;
                    rresp_q <= `DTST_RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // input selection and edges
    // ----------------------------------------------------------------
    logic trig, en, tmrRun, held;
    logic trigPrev_q, enPrev_q, faultPrev_q;
    logic rise, enRise, start, ok, unitTick;

    always_comb begin
        case (ctrl_q.trigSel)
            TRIG_PIN: trig = trigSync;
            TRIG_NEST: trig = nestOut;
            TRIG_SOFT: trig = soft_q[`DTST_SOFT_TRIG];
            TRIG_HIGH: trig = 1'b1;
            default: trig = 1'b0;
        endcase
        case (ctrl_q.enaSel)
            ENA_ALWAYS: en = 1'b1;
            ENA_NEVER: en = 1'b0;
            ENA_PIN: en = enaSync;
            ENA_SOFT: en = soft_q[`DTST_SOFT_ENA];
            default: en = 1'b0;
        endcase
    end

    assign tmrRun = runSync && soft_q[`DTST_SOFT_RUN];
    assign ok = tmrRun && !faultSync && !faultPrev_q;
    // inputs are sampled while disabled; starting from idle and updating timerOut wait on enable
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            trigPrev_q <= 1'b0;
            enPrev_q <= 1'b0;
            faultPrev_q <= 1'b0;
        end else begin
            trigPrev_q <= trig;
            enPrev_q <= en;
            faultPrev_q <= faultSync;
        end
    end
    assign rise = trig && !trigPrev_q;
    // a trigger already high at enable acts as an edge; relies on
    assign enRise = en && !enPrev_q;
    assign start = en && (rise || (enRise && trig));

    // ----------------------------------------------------------------
    // accumulator and state
    // ----------------------------------------------------------------
    dtst_tick_gen #(
        .MS_CYCLES(MS_CYCLES)
    ) u_tick (
        .ref_clk(ref_clk),
        .rstSync_n(rstSync_n),
        .clr(state_q != ST_RUN),
        .freeze(faultSync),
        .unit(ctrl_q.unit),
        .unitTick(unitTick)
    );

    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_q <= ST_IDLE;
            acc_q <= '0;
        end else if (faultSync) begin
            state_q <= state_q;
        end else if (faultPrev_q) begin
            state_q <= ST_IDLE;
            acc_q <= '0;
        end else if (!tmrRun) begin
            state_q <= ST_WAIT;
            acc_q <= '0;
        end else begin
            case (state_q)
                ST_WAIT: begin
                    state_q <= trig ? ST_RUN : ST_IDLE;
                    acc_q <= '0;
                end
                ST_IDLE: begin
                    if (start) begin
                        state_q <= ST_RUN;
                        acc_q <= '0;
                    end
                end
                ST_RUN: begin
                    if (!trig) begin
                        state_q <= ST_IDLE;
                        acc_q <= '0;
                    end else if (acc_q >= tally_q) begin
                        state_q <= ST_HOLD;
                        acc_q <= tally_q;
                    end else if (unitTick) begin
                        acc_q <= acc_q + 15'h0001;
                        if (acc_q + 15'h0001 == tally_q) begin
                            state_q <= ST_HOLD;
                        end
                    end
                end
                ST_HOLD: begin
                    if (!trig) begin
                        state_q <= ST_IDLE;
                        acc_q <= '0;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    acc_q <= '0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // output
    // ----------------------------------------------------------------
    assign held = (state_q == ST_HOLD);

    // stays low from power-up until the first enabled update
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            outQ <= 1'b0;
        end else if (en && !faultSync) begin
            outQ <= held ^ ctrl_q.invert;
        end
    end
    assign timerOut = outQ;

    assign status = '{fault: faultSync, enabled: en,
                      running: (state_q == ST_RUN), held: held,
                      outLevel: outQ, acc: acc_q};

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstSync_n);

    logic [14:0] accPrev_q;
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            accPrev_q <= '0;
        end else begin
            accPrev_q <= acc_q;
        end
    end

    a_rise_starts: assert property (
        state_q == ST_IDLE && ok && rise && en |=> state_q == ST_RUN
            && acc_q == 15'h0000)
        else $error("trigger edge did not start timing");
    a_count_step: assert property (
        state_q == ST_RUN && ok && trig && unitTick && acc_q < tally_q
            |=> acc_q == accPrev_q + 15'h0001)
        else $error("accumulator did not step by one unit");
    a_reset_halts: assert property (
        !tmrRun && !faultSync && !faultPrev_q |=> acc_q == 15'h0000
            && state_q == ST_WAIT)
        else $error("timer counted while reset low");
    a_tally_range: assert property (tally_q >= `DTST_TALLY_MIN)
        else $error("final tally left its range");
    a_hold_keeps: assert property (
        held && ok && trig |=> held && acc_q == accPrev_q)
        else $error("held tally was not kept");
    a_out_std: assert property (
        en && !faultSync && !ctrl_q.invert |=> outQ == $past(held))
        else $error("standard output does not follow hold");
    a_out_inv: assert property (
        en && !faultSync && ctrl_q.invert |=> outQ == !$past(held))
        else $error("inverted output does not follow hold");
    a_fall_clears: assert property (
        (state_q == ST_RUN || held) && ok && !trig
            |=> state_q == ST_IDLE && acc_q == 15'h0000)
        else $error("falling trigger did not clear accumulator");
    a_out_frozen: assert property (
        !en || faultSync |=> $stable(outQ))
        else $error("output moved while disabled or in fallback");
    a_enable_edge: assert property (
        state_q == ST_IDLE && ok && enRise && trig |=> state_q == ST_RUN)
        else $error("trigger high at enable did not start timing");
    a_fault_restart: assert property (
        !faultSync && faultPrev_q |=> state_q == ST_IDLE
            && acc_q == 15'h0000)
        else $error("timer not cleared after fallback");
    a_reset_restart: assert property (
        state_q == ST_WAIT && ok && trig |=> state_q == ST_RUN
            && acc_q == 15'h0000)
        else $error("reset release with trigger high did not restart");

    c_reach_hold: cover property (state_q == ST_RUN ##1 held);
    c_early_fall: cover property (state_q == ST_RUN && !trig && ok);
    c_enable_start: cover property (enRise && trig && state_q == ST_IDLE);
    c_fallback: cover property (faultPrev_q && !faultSync);

endmodule

// [common/dtst_cfg.svh]
// offsets, field positions, reset values and timing counts of the timer
`ifndef DTST_CFG_SVH
`define DTST_CFG_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define DTST_AW 4
`define DTST_OFS_CTRL 4'h0
`define DTST_OFS_TALLY 4'h4
`define DTST_OFS_STATUS 4'h8
`define DTST_OFS_SOFT 4'hC

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define DTST_CTRL_RST 8'h00
`define DTST_TALLY_RST 15'h0001
`define DTST_TALLY_MIN 15'h0001
`define DTST_SOFT_RST 3'h4
`define DTST_SOFT_TRIG 0
`define DTST_SOFT_ENA 1
`define DTST_SOFT_RUN 2
`define DTST_UNIT_MAX 3'h4

// ----------------------------------------------------------------
// time units in ms and the clock
// ----------------------------------------------------------------
`define DTST_UNIT_1_MS 14'h0001
`define DTST_UNIT_10_MS 14'h000A
`define DTST_UNIT_100_MS 14'h0064
`define DTST_UNIT_1000_MS 14'h03E8
`define DTST_UNIT_10000_MS 14'h2710
`define DTST_MS_NS 1000000
`define DTST_CLK_NS 20
`define DTST_MS_CYCLES (`DTST_MS_NS / `DTST_CLK_NS)

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define DTST_RESP_OKAY 2'h0
`define DTST_RESP_SLVERR 2'h2

`endif

// [common/dtst_pkg.sv]
// types and shared functions of the delay-to-start timer
package dtst_pkg;
`include "dtst_cfg.svh"

    typedef enum logic [1:0] {
        ENA_ALWAYS,
        ENA_NEVER,
        ENA_PIN,
        ENA_SOFT
    } dtst_ena_sel_t;

    typedef enum logic [1:0] {
        TRIG_PIN,
        TRIG_NEST,
        TRIG_SOFT,
        TRIG_HIGH
    } dtst_trig_sel_t;

    typedef enum logic [2:0] {
        UNIT_1MS,
        UNIT_10MS,
        UNIT_100MS,
        UNIT_1000MS,
        UNIT_10000MS
    } dtst_unit_t;

    typedef enum {
        ST_IDLE,
        ST_RUN,
        ST_HOLD,
        ST_WAIT
    } dtst_state_t;

    typedef struct packed {
        logic invert;
        dtst_unit_t unit;
        dtst_trig_sel_t trigSel;
        dtst_ena_sel_t enaSel;
    } dtst_ctrl_t;

    typedef struct packed {
        logic fault;
        logic enabled;
        logic running;
        logic held;
        logic outLevel;
        logic [14:0] acc;
    } dtst_status_t;

    function automatic logic [13:0] dtst_unit_len(dtst_unit_t u);
        case (u)
            UNIT_1MS: dtst_unit_len = `DTST_UNIT_1_MS;
            UNIT_10MS: dtst_unit_len = `DTST_UNIT_10_MS;
            UNIT_100MS: dtst_unit_len = `DTST_UNIT_100_MS;
            UNIT_1000MS: dtst_unit_len = `DTST_UNIT_1000_MS;
            UNIT_10000MS: dtst_unit_len = `DTST_UNIT_10000_MS;
            default: dtst_unit_len = `DTST_UNIT_1_MS;
        endcase
    endfunction

    function automatic logic [31:0] dtst_merge(logic [31:0] old,
                                               logic [31:0] wd,
                                               logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

endpackage

// [src/dtst_tick_gen.sv]
// millisecond prescaler and time-unit scaler of the timer
module dtst_tick_gen #(
    parameter int unsigned MS_CYCLES = `DTST_MS_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstSync_n,
    // control
    input wire logic clr,
    input wire logic freeze,
    input wire dtst_pkg::dtst_unit_t unit,
    // strobe
    output logic unitTick
);
    import dtst_pkg::*;

    localparam int MSW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;

    logic [MSW-1:0] msCnt_q;
    logic [13:0] unitCnt_q;
    logic msTick;
    logic [13:0] unitLen;

    // ----------------------------------------------------------------
    // 1 ms tick
    // ----------------------------------------------------------------
    assign msTick = !freeze && (msCnt_q == MSW'(MS_CYCLES - 1));

    // cleared on start so the first unit is never short
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            msCnt_q <= '0;
        end else if (clr) begin
            msCnt_q <= '0;
        end else if (msTick) begin
            msCnt_q <= '0;
        end else if (!freeze) begin
            msCnt_q <= msCnt_q + MSW'(1);
        end
    end

    // ----------------------------------------------------------------
    // unit scaler
    // ----------------------------------------------------------------
    assign unitLen = dtst_unit_len(unit);
    assign unitTick = msTick && (unitCnt_q >= unitLen - 14'h0001);

    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            unitCnt_q <= '0;
        end else if (clr || unitTick) begin
            unitCnt_q <= '0;
        end else if (msTick) begin
            unitCnt_q <= unitCnt_q + 14'h0001;
        end
    end

endmodule

// [bench/dtst_island_model.sv]
// island-side model of the level sources that feed the timer
module dtst_island_model (
    // clock
    input wire logic ref_clk,
    // levels toward the timer
    output logic trigPin,
    output logic enablePin,
    output logic timerReset_n,
    output logic faultPin,
    output logic nestOut
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // levels, packed as trigger, enable, run, fault, nested
    // ------------------------------------------------------------
    // trigger low from start-up so enabling starts nothing
    initial begin
        {trigPin, enablePin, timerReset_n} = 3'h3;
        {faultPin, nestOut} = 2'h0;
    end
    task automatic put(input logic [4:0] lv);
        @(posedge ref_clk);
        {trigPin, enablePin, timerReset_n, faultPin, nestOut} <= lv;
    endtask
endmodule

// [bench/tb_dtst_timer.sv]
// self-checking bench of the delay-to-start timer
module tb_dtst_timer;
    timeunit 1ns;
    timeprecision 1ps;
    // short prescaler keeps the 10 s unit affordable
    localparam int MSC = 4;
    logic ref_clk = 1'h0;
    logic rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, v;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, timerOut;
    logic trigPin, enablePin, timerReset_n, faultPin, nestOut;
    int err_total = 0, compares = 0, n;
    always #10 ref_clk = ~ref_clk;
    dtst_island_model u_src (.ref_clk(ref_clk), .trigPin(trigPin),
        .enablePin(enablePin), .timerReset_n(timerReset_n),
        .faultPin(faultPin), .nestOut(nestOut));
    dtst_timer #(.MS_CYCLES(MSC)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .trigPin(trigPin), .enablePin(enablePin), .nestOut(nestOut),
        .timerReset_n(timerReset_n), .faultPin(faultPin),
        .timerOut(timerOut));
    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s exp %0h seen %0h", s, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // bus master: handshakes judged at the falling edge before
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hF);
        logic ta, tw, tb;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        tb = 1'h0;
        while (!tb) begin
            @(negedge ref_clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            r = bresp;
            @(posedge ref_clk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
        end
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a);
        logic ta, tb;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        tb = 1'h0;
        while (!tb) begin
            @(negedge ref_clk);
            ta = arvalid && arready;
            tb = rvalid && rready;
            v = rdata;
            r = rresp;
            @(posedge ref_clk);
            if (ta) arvalid <= 1'h0;
        end
        rready <= 1'h0;
    endtask
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic cfg(input logic [7:0] c, input logic [14:0] t);
        wr(4'h4, {17'h0, t});
        chk("tally resp", r, 2'h0);
        wr(4'h0, {24'h0, c});
        chk("ctrl resp", r, 2'h0);
    endtask
    task automatic meas(input logic o, input int lo, input int hi);
        n = 0;
        while (timerOut !== o && n <= hi) begin
            @(negedge ref_clk);
            n++;
        end
        chk("delay ok", n >= lo && n <= hi, 1'h1);
    endtask
    task automatic quiet(input logic o, input int c);
        n = 0;
        repeat (c) begin
            @(negedge ref_clk);
            if (timerOut !== o) n++;
        end
        chk("steady", n, 0);
    endtask
    task automatic stat(input logic [14:0] acc, input logic held);
        rd(4'h8);
        chk("acc", v[14:0], acc);
        chk("held", v[16], held);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        chk("out", timerOut, 1'h0);
        rd(4'h0);
        chk("ctrl", v, 32'h0);
        rd(4'h4);
        chk("tally", v, 32'h1);
        rd(4'hC);
        chk("soft", v, 32'h4);
        rd(4'h2);
        chk("hole", r, 2'h2);
        wr(4'h8, 32'h0);
        chk("status ro", r, 2'h2);
        wr(4'h4, 32'h0);
        chk("tally 0", r, 2'h2);
        wr(4'h0, 32'h50);
        chk("unit 5", r, 2'h2);
    endtask
    task automatic t_units;
        int ms[5] = '{1, 10, 100, 1000, 10000};
        int t;
        for (int u = 0; u < 5; u++) begin
            t = (u == 0) ? 7 : 1;
            cfg({1'h0, 3'(u), 4'h0}, 15'(t));
            u_src.put(5'h1C);
            meas(1'h1, MSC * t * ms[u], MSC * t * ms[u] + 8);
            stat(15'(t), 1'h1);
            u_src.put(5'h0C);
            meas(1'h0, 0, 8);
            stat(15'h0, 1'h0);
        end
    endtask
    task automatic t_early;
        u_src.put(5'h1C);
        repeat (10) @(posedge ref_clk);
        u_src.put(5'h0C);
        quiet(1'h0, 40);
        stat(15'h0, 1'h0);
    endtask
    task automatic t_halt;
        cfg(8'h00, 15'h5);
        u_src.put(5'h1C);
        repeat (8) @(posedge ref_clk);
        u_src.put(5'h18);
        quiet(1'h0, 40);
        stat(15'h0, 1'h0);
        u_src.put(5'h1C);
        meas(1'h1, 20, 28);
        u_src.put(5'h0C);
        meas(1'h0, 0, 8);
    endtask
    task automatic t_inv_nest;
        cfg(8'h80, 15'h3);
        meas(1'h1, 0, 8);
        u_src.put(5'h1C);
        meas(1'h0, 12, 20);
        u_src.put(5'h0C);
        meas(1'h1, 0, 8);
        cfg(8'h04, 15'h3);
        u_src.put(5'h0D);
        meas(1'h1, 12, 20);
        u_src.put(5'h0C);
        meas(1'h0, 0, 8);
    endtask
    task automatic t_enable;
        cfg(8'h02, 15'h3);
        u_src.put(5'h1C);
        meas(1'h1, 12, 20);
        u_src.put(5'h14);
        u_src.put(5'h04);
        quiet(1'h1, 30);
        stat(15'h0, 1'h0);
        u_src.put(5'h0C);
        meas(1'h0, 0, 8);
        u_src.put(5'h04);
        u_src.put(5'h14);
        quiet(1'h0, 40);
        u_src.put(5'h1C);
        meas(1'h1, 12, 20);
        u_src.put(5'h0C);
        meas(1'h0, 0, 8);
        cfg(8'h01, 15'h3);
        u_src.put(5'h1C);
        quiet(1'h0, 40);
        u_src.put(5'h0C);
    endtask
    task automatic t_fault;
        cfg(8'h00, 15'h3);
        u_src.put(5'h1C);
        meas(1'h1, 12, 20);
        u_src.put(5'h1E);
        u_src.put(5'h0E);
        quiet(1'h1, 30);
        u_src.put(5'h0C);
        meas(1'h0, 0, 8);
        stat(15'h0, 1'h0);
    endtask
    // software trigger, enable and run bits, then a constant trigger
    task automatic t_soft;
        cfg(8'h0B, 15'h3);
        wr(4'hC, 32'h7);
        meas(1'h1, 12, 20);
        wr(4'hC, 32'h0, 4'h0);
        chk("strb resp", r, 2'h0);
        rd(4'hC);
        chk("strb kept", v, 32'h7);
        wr(4'hC, 32'h3);
        meas(1'h0, 0, 8);
        wr(4'hC, 32'h7);
        meas(1'h1, 12, 20);
        wr(4'hC, 32'h6);
        meas(1'h0, 0, 8);
        cfg(8'h0C, 15'h3);
        meas(1'h1, 12, 20);
        cfg(8'h00, 15'h3);
        meas(1'h0, 0, 8);
    endtask
    initial begin
        rst_n <= 1'h0;
        {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
        {awaddr, araddr, wstrb, wdata} <= 44'h0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'h1;
        repeat (6) @(posedge ref_clk);
        t_regs();
        t_units();
        t_early();
        t_halt();
        t_inv_nest();
        t_enable();
        t_fault();
        t_soft();
        end_of_test();
    end
    // whole run needs about 50k cycles
    initial begin
        #2000000;
        err_total++;
        end_of_test();
    end
endmodule
